// >>> src/cmg_pkg.sv
// Package: register map, field positions and reset values for mask gating
package cmg_pkg;
    // Register index of the single control register
    localparam logic [3:0]  CMG_CTRL_ADDR      = 4'h0;
    // Register index of the read-only status register
    localparam logic [3:0]  CMG_STAT_ADDR      = 4'h1;
    // Control register reset value
    localparam logic [15:0] CMG_CTRL_RST       = 16'h0000;
    // Bits that software may write; bit 14 is unimplemented
    localparam logic [15:0] CMG_CTRL_WMASK     = 16'hBFFF;
    // Field positions
    localparam int          CMG_POL_BIT        = 15;
    localparam int          CMG_OR_C_T_BIT     = 13;
    localparam int          CMG_OR_C_N_BIT     = 12;
    localparam int          CMG_OR_B_T_BIT     = 11;
    localparam int          CMG_OR_B_N_BIT     = 10;
    localparam int          CMG_OR_A_T_BIT     = 9;
    localparam int          CMG_OR_A_N_BIT     = 8;
    localparam int          CMG_AND_N_BIT      = 7;
    localparam int          CMG_AND_T_BIT      = 6;
    localparam int          CMG_AND_C_T_BIT    = 5;
    localparam int          CMG_AND_C_N_BIT    = 4;
    localparam int          CMG_AND_B_T_BIT    = 3;
    localparam int          CMG_AND_B_N_BIT    = 2;
    localparam int          CMG_AND_A_T_BIT    = 1;
    localparam int          CMG_AND_A_N_BIT    = 0;
    // Status fields
    localparam int          CMG_ST_BLANK_BIT   = 0;
    localparam int          CMG_ST_OUT_BIT     = 1;
    localparam int          CMG_ST_AND_BIT     = 2;
    // Zero word
    localparam logic [15:0] CMG_ZERO16         = 16'h0000;
endpackage : cmg_pkg

// >>> src/cmg_gate.sv
// Generic gate: combines enabled true and inverted inputs by AND or OR
module cmg_gate
    import cmg_pkg::*;
#(
    parameter int N      = 3,
    parameter bit IS_AND = 1'b0
) (
    // Inputs and per-input enables
    input  wire logic [N-1:0] sig_in,
    input  wire logic [N-1:0] en_true,
    input  wire logic [N-1:0] en_inv,
    // Gate result
    output wire logic         gate_out
);
    // Disabled terms become neutral for the chosen operator
    wire logic [N-1:0] term_t;
    wire logic [N-1:0] term_n;
    assign term_t = IS_AND ? (sig_in | ~en_true) : (sig_in & en_true);
    assign term_n = IS_AND ? (~sig_in | ~en_inv) : (~sig_in & en_inv);
    // An AND with nothing enabled gives 0, so it cannot blank through the true path
    wire logic any_en;
    assign any_en   = |(en_true | en_inv);
    assign gate_out = IS_AND ? (any_en & (&term_t) & (&term_n))
                             : ((|term_t) | (|term_n));
endmodule : cmg_gate

// >>> src/cmg_regs.sv
// Control register with unimplemented bit held at zero
module cmg_regs
    import cmg_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Write side
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // Stored value
    output wire logic [15:0] ctrl
);
    logic [15:0] ctrl_r;   // Control register
    logic [15:0] ctrl_nxt; // Next value
    // Masking on write keeps bit 14 at zero forever
    assign ctrl_nxt = wr_en ? (wr_data & CMG_CTRL_WMASK) : ctrl_r;
    // Register update
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r <= CMG_CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end
    assign ctrl = ctrl_r;
endmodule : cmg_regs

// >>> src/cmg_top.sv
// Top: comparator mask gating with register port
//
// The address-and-strobe port and the register offsets were decided locally.
module cmg_top
    import cmg_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Comparator and mask sources
    input  wire logic        cmp_in,
    input  wire logic        mask_input_a,
    input  wire logic        mask_input_b,
    input  wire logic        mask_input_c,
    // Gated comparator
    output logic             cmp_out,
    output logic             blank_active
);
    // Control register contents
    wire logic [15:0] ctrl;
    wire logic        wr_ctrl;
    assign wr_ctrl = reg_wr && (reg_addr == CMG_CTRL_ADDR);

    // Register storage
    cmg_regs u_regs (
        .core_clk (core_clk),
        .reset    (reset),
        .wr_en    (wr_ctrl),
        .wr_data  (reg_wdata),
        .ctrl     (ctrl)
    );

    // Field extraction, index 2 is C, 1 is B, 0 is A
    wire logic [2:0] mask_in;
    wire logic [2:0] or_t;
    wire logic [2:0] or_n;
    wire logic [2:0] and_t;
    wire logic [2:0] and_n;
    assign mask_in = {mask_input_c, mask_input_b, mask_input_a};
    assign or_t  = {ctrl[CMG_OR_C_T_BIT], ctrl[CMG_OR_B_T_BIT],
                    ctrl[CMG_OR_A_T_BIT]};
    assign or_n  = {ctrl[CMG_OR_C_N_BIT], ctrl[CMG_OR_B_N_BIT],
                    ctrl[CMG_OR_A_N_BIT]};
    assign and_t = {ctrl[CMG_AND_C_T_BIT], ctrl[CMG_AND_B_T_BIT],
                    ctrl[CMG_AND_A_T_BIT]};
    assign and_n = {ctrl[CMG_AND_C_N_BIT], ctrl[CMG_AND_B_N_BIT],
                    ctrl[CMG_AND_A_N_BIT]};

    // AND gate over the enabled mask terms
    wire logic and_gate_result;
    cmg_gate #(.N(3), .IS_AND(1'b1)) u_and (
        .sig_in   (mask_in),
        .en_true  (and_t),
        .en_inv   (and_n),
        .gate_out (and_gate_result)
    );

    // OR gate: mask terms plus AND result as a fourth input
    wire logic blank_nxt;
    cmg_gate #(.N(4), .IS_AND(1'b0)) u_or (
        .sig_in   ({and_gate_result, mask_in}),
        .en_true  ({ctrl[CMG_AND_T_BIT], or_t}),
        .en_inv   ({ctrl[CMG_AND_N_BIT], or_n}),
        .gate_out (blank_nxt)
    );

    // Blanking forces the output to the non-asserted level
    wire logic pol;
    wire logic cmp_nxt;
    assign pol     = ctrl[CMG_POL_BIT];
    // Asserted level is 0 when pol is 1, so blank drives 1, and vice versa
    assign cmp_nxt = blank_nxt ? pol : cmp_in;

    // Status word and read mux
    wire logic [15:0] status;
    wire logic [15:0] rd_mux;
    assign status = {13'h0000, and_gate_result, cmp_out, blank_active};
    assign rd_mux = (reg_addr == CMG_CTRL_ADDR) ? ctrl :
                    (reg_addr == CMG_STAT_ADDR) ? status : CMG_ZERO16;

    // Registered outputs; one cycle latency is the price of glitch-free pins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmp_out      <= 1'b0;
            blank_active <= 1'b0;
            reg_rdata    <= CMG_ZERO16;
        end else begin
            cmp_out      <= cmp_nxt;
            blank_active <= blank_nxt;
            reg_rdata    <= reg_rd ? rd_mux : CMG_ZERO16;
        end
    end

    // Assertions. Each guards one behaviour of the gating or the register port.
    // Antecedents, bar the AND input and reset checks, carry !reset: at the edge that releases reset the
    // sampled reset is still high while the current one is already low,
    // and the outputs launched there still hold their reset values.

    // Reference for the checks, written term by term from the field
    // positions so that a fault inside the gate module cannot hide itself
    wire logic ref_and_any; // Some AND input is enabled
    wire logic ref_and;     // Expected AND gate result
    wire logic ref_blank;   // Expected OR gate result
    assign ref_and_any = ctrl[CMG_AND_C_T_BIT] | ctrl[CMG_AND_C_N_BIT]
                       | ctrl[CMG_AND_B_T_BIT] | ctrl[CMG_AND_B_N_BIT]
                       | ctrl[CMG_AND_A_T_BIT] | ctrl[CMG_AND_A_N_BIT];
    // An empty AND reads as 0, so it never blanks through the true path
    assign ref_and = ref_and_any
                   & (~ctrl[CMG_AND_C_T_BIT] | mask_input_c)
                   & (~ctrl[CMG_AND_C_N_BIT] | ~mask_input_c)
                   & (~ctrl[CMG_AND_B_T_BIT] | mask_input_b)
                   & (~ctrl[CMG_AND_B_N_BIT] | ~mask_input_b)
                   & (~ctrl[CMG_AND_A_T_BIT] | mask_input_a)
                   & (~ctrl[CMG_AND_A_N_BIT] | ~mask_input_a);
    // Every enabled OR term, the AND result in either form included
    assign ref_blank = (ctrl[CMG_OR_C_T_BIT] & mask_input_c)
                     | (ctrl[CMG_OR_C_N_BIT] & ~mask_input_c)
                     | (ctrl[CMG_OR_B_T_BIT] & mask_input_b)
                     | (ctrl[CMG_OR_B_N_BIT] & ~mask_input_b)
                     | (ctrl[CMG_OR_A_T_BIT] & mask_input_a)
                     | (ctrl[CMG_OR_A_N_BIT] & ~mask_input_a)
                     | (ctrl[CMG_AND_T_BIT] & ref_and)
                     | (ctrl[CMG_AND_N_BIT] & ~ref_and);

    // Polarity and pass-through
    // Blanked cycle shows the level that the polarity bit calls inactive
    AST_POL_BLANK: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && blank_nxt |=> cmp_out == $past(pol))
        else $error("blanked output not at inactive level");
    // Unblanked cycle passes the comparator level one cycle late
    AST_PASS: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && !blank_nxt |=> cmp_out == $past(cmp_in))
        else $error("unblanked output not following comparator");

    // OR gate sources, one per enable bit
    // C true term blanks while C is high
    AST_OR_C_T: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_OR_C_T_BIT] && mask_input_c |=> blank_active)
        else $error("C true did not blank");
    // C inverted term blanks while C is low
    AST_OR_C_N: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_OR_C_N_BIT] && !mask_input_c |=> blank_active)
        else $error("C inverted did not blank");
    // B true term blanks while B is high
    AST_OR_B_T: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_OR_B_T_BIT] && mask_input_b |=> blank_active)
        else $error("B true did not blank");
    // B inverted term blanks while B is low
    AST_OR_B_N: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_OR_B_N_BIT] && !mask_input_b |=> blank_active)
        else $error("B inverted did not blank");
    // A true term blanks while A is high
    AST_OR_A_T: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_OR_A_T_BIT] && mask_input_a |=> blank_active)
        else $error("A true did not blank");
    // A inverted term blanks while A is low
    AST_OR_A_N: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_OR_A_N_BIT] && !mask_input_a |=> blank_active)
        else $error("A inverted did not blank");

    // AND result routed into the OR gate
    // Inverted AND result blanks while the AND is low
    AST_AND_N: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_AND_N_BIT] && !and_gate_result |=> blank_active)
        else $error("inverted AND result did not blank");
    // True AND result blanks while the AND is high
    AST_AND_T: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl[CMG_AND_T_BIT] && and_gate_result |=> blank_active)
        else $error("AND result did not blank");

    // AND gate inputs: an enabled term that is false forces the AND low
    // C true enabled and C low
    AST_AND_C: assert property (
        @(posedge core_clk) disable iff (reset)
        ctrl[CMG_AND_C_T_BIT] && !mask_input_c |-> !and_gate_result)
        else $error("AND high with C true enabled and C low");
    // C inverted enabled and C high
    AST_AND_CN: assert property (
        @(posedge core_clk) disable iff (reset)
        ctrl[CMG_AND_C_N_BIT] && mask_input_c |-> !and_gate_result)
        else $error("AND high with C inverted enabled and C high");
    // B true enabled and B low
    AST_AND_B_T: assert property (
        @(posedge core_clk) disable iff (reset)
        ctrl[CMG_AND_B_T_BIT] && !mask_input_b |-> !and_gate_result)
        else $error("AND high with B true enabled and B low");
    // B inverted enabled and B high
    AST_AND_B_N: assert property (
        @(posedge core_clk) disable iff (reset)
        ctrl[CMG_AND_B_N_BIT] && mask_input_b |-> !and_gate_result)
        else $error("AND high with B inverted enabled and B high");
    // A true enabled and A low
    AST_AND_A_T: assert property (
        @(posedge core_clk) disable iff (reset)
        ctrl[CMG_AND_A_T_BIT] && !mask_input_a |-> !and_gate_result)
        else $error("AND high with A true enabled and A low");
    // A inverted enabled and A high
    AST_AND_A_N: assert property (
        @(posedge core_clk) disable iff (reset)
        ctrl[CMG_AND_A_N_BIT] && mask_input_a |-> !and_gate_result)
        else $error("AND high with A inverted enabled and A high");

    // Whole gate network against the reference, plus the nothing-enabled case
    // AND result equals the AND of its enabled terms
    AST_AND_REF: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset |-> and_gate_result == ref_and)
        else $error("AND result differs from reference");
    // Disabled terms must not blank either, which the single checks miss
    AST_BLANK_REF: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset |=> blank_active == $past(ref_blank))
        else $error("blanking differs from reference");
    // Nothing enabled means nothing blanks
    AST_NO_EN: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && ctrl == CMG_ZERO16 |=> !blank_active)
        else $error("blanking with nothing enabled");

    // Register port
    // Unimplemented bit never holds a one
    AST_CTRL_B14: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset |-> (ctrl & ~CMG_CTRL_WMASK) == CMG_ZERO16)
        else $error("unimplemented control bit set");
    // Unimplemented bit reads back as zero
    AST_BIT14: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && reg_rd && reg_addr == CMG_CTRL_ADDR |=>
            (reg_rdata & ~CMG_CTRL_WMASK) == CMG_ZERO16)
        else $error("bit 14 read nonzero");
    // A control write lands in the next cycle, masked
    AST_WR_LAND: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && wr_ctrl |=> ctrl == ($past(reg_wdata) & CMG_CTRL_WMASK))
        else $error("control write did not land");
    // Without a control write the register keeps its value
    AST_WR_HOLD: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && !wr_ctrl |=> ctrl == $past(ctrl))
        else $error("control register changed without a write");
    // Control read returns the stored word
    AST_RD_CTRL: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && reg_rd && reg_addr == CMG_CTRL_ADDR |=>
            reg_rdata == $past(ctrl))
        else $error("control read does not match stored word");
    // Status read returns the live state of the strobe cycle
    AST_RD_STAT: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && reg_rd && reg_addr == CMG_STAT_ADDR |=> reg_rdata ==
            {13'h0000, $past(and_gate_result), $past(cmp_out),
             $past(blank_active)})
        else $error("status read does not match the live state");
    // Read data stand one cycle only, zero otherwise
    AST_RD_IDLE: assert property (
        @(posedge core_clk) disable iff (reset)
        !reset && !reg_rd |=> reg_rdata == CMG_ZERO16)
        else $error("read data not zero outside a read");

    // Reset
    // Reset clears every registered output at the next edge
    AST_RST: assert property (
        @(posedge core_clk)
        reset |=> !cmp_out && !blank_active && reg_rdata == CMG_ZERO16)
        else $error("outputs not cleared by reset");

    // Cover points for the main scenarios
    // Polarity 1 blanking a low comparator level
    COV_BLANK_HI: cover property (@(posedge core_clk) disable iff (reset)
        blank_active && pol && !cmp_in);
    // Polarity 0 blanking a high comparator level
    COV_BLANK_LO: cover property (@(posedge core_clk) disable iff (reset)
        blank_active && !pol && cmp_in);
    // True AND result routed to the OR gate and high
    COV_AND_HIT: cover property (@(posedge core_clk) disable iff (reset)
        and_gate_result && ctrl[CMG_AND_T_BIT]);
    // Inverted AND result doing the blanking
    COV_AND_INV: cover property (@(posedge core_clk) disable iff (reset)
        !and_gate_result && ctrl[CMG_AND_N_BIT] && blank_nxt);
    // Write followed at once by a read
    COV_RD: cover property (@(posedge core_clk) disable iff (reset)
        reg_wr ##1 reg_rd);
endmodule : cmg_top

// >>> sim/cmg_src_model.sv
// Partner model: comparator and mask source levels seen by the gating block
module cmg_src_model (
    // Clock
    input  wire logic       core_clk,
    // Requested levels, {cmp, c, b, a}
    input  wire logic [3:0] level_req,
    // Source levels, launched on the clock like a synchronised source
    output logic            cmp_in,
    output logic            mask_input_a,
    output logic            mask_input_b,
    output logic            mask_input_c
);
    timeunit 1ns;
    timeprecision 1ns;
    // Registered so the levels never move in the gating block's sample step
    always_ff @(posedge core_clk) begin
        {cmp_in, mask_input_c, mask_input_b, mask_input_a} <= level_req;
    end
endmodule : cmg_src_model

// >>> sim/cmg_top_test.sv
// Testbench: gating table, register port and reset checks for cmg_top
module cmg_top_test;
    import cmg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // One row: control word, levels {cmp,c,b,a}, expected blank and output
    typedef struct packed {
        logic [15:0] ctrl;
        logic [3:0]  lv;
        logic        blank;
        logic        out;
    } cmg_row_type;
    localparam cmg_row_type ROWS [15] = '{
        '{16'h2000, 4'hC, 1'b1, 1'b0}, '{16'h1000, 4'h8, 1'b1, 1'b0},
        '{16'h8800, 4'h2, 1'b1, 1'b1}, '{16'h0400, 4'hA, 1'b0, 1'b1},
        '{16'h0200, 4'h9, 1'b1, 1'b0}, '{16'h0100, 4'h8, 1'b1, 1'b0},
        '{16'h0060, 4'hC, 1'b1, 1'b0}, '{16'h0060, 4'h8, 1'b0, 1'b1},
        '{16'h0090, 4'h8, 1'b0, 1'b1}, '{16'h0090, 4'hC, 1'b1, 1'b0},
        '{16'h8000, 4'h0, 1'b0, 1'b0}, '{16'h0070, 4'hC, 1'b0, 1'b1},
        '{16'h0049, 4'hA, 1'b1, 1'b0}, '{16'h0046, 4'h9, 1'b1, 1'b0},
        '{16'h0046, 4'hB, 1'b0, 1'b1}};
    logic        core_clk  = 1'b0;  // 20 MHz clock
    logic        reset     = 1'b1;  // Held for six cycles at start
    logic [3:0]  reg_addr  = 4'h0;  // Register index
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0]  level_req = 4'h0;  // Levels handed to the source model
    logic        cmp_in, mask_input_a, mask_input_b, mask_input_c;
    logic        cmp_out, blank_active;
    logic [15:0] rd_val;            // Last word read back
    int          fail_count = 0;
    int          compares   = 0;
    // Clock generation
    always #25 core_clk = ~core_clk;
    cmg_src_model src (.core_clk(core_clk), .level_req(level_req),
        .cmp_in(cmp_in), .mask_input_a(mask_input_a),
        .mask_input_b(mask_input_b), .mask_input_c(mask_input_c));
    cmg_top dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmp_in(cmp_in), .mask_input_a(mask_input_a),
        .mask_input_b(mask_input_b), .mask_input_c(mask_input_c),
        .cmp_out(cmp_out), .blank_active(blank_active));
    // Compare tasks, one per result width
    task automatic chk16(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk16
    task automatic chk1(input string n, input logic e, input logic g);
        chk16(n, {15'h0000, e}, {15'h0000, g});
    endtask : chk1
    // Bus cycles start right after a rising edge and end right after one
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : bus_wr
    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        rd_val = reg_rdata;
        @(posedge core_clk);
    endtask : bus_rd
    // Verdict and end of run
    task automatic results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    // Watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        results();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        chk1("out_rst", 1'b0, cmp_out);
        chk1("blank_rst", 1'b0, blank_active);
        @(posedge core_clk);
        bus_rd(CMG_CTRL_ADDR);
        chk16("ctrl_rst", CMG_CTRL_RST, rd_val);
        $display("test reset done");
        // Table of gating cases; source levels move one cycle after the write lands
        foreach (ROWS[i]) begin
            bus_wr(CMG_CTRL_ADDR, ROWS[i].ctrl);
            level_req <= ROWS[i].lv;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            chk1("blank", ROWS[i].blank, blank_active);
            chk1("cmp_out", ROWS[i].out, cmp_out);
            @(posedge core_clk);
            bus_rd(CMG_CTRL_ADDR);
            chk16("ctrl", ROWS[i].ctrl, rd_val);
        end
        $display("test gating table done");
        // Unimplemented bit, back-to-back write then read
        bus_wr(CMG_CTRL_ADDR, 16'hFFFF);
        bus_rd(CMG_CTRL_ADDR);
        chk16("ctrl_b14", 16'hBFFF, rd_val);
        @(negedge core_clk);
        chk16("rdata_idle", 16'h0000, reg_rdata);
        @(posedge core_clk);
        // Status view, write to status ignored, unmapped read zero
        bus_wr(CMG_CTRL_ADDR, 16'h0200);
        level_req <= 4'h1;
        repeat (3) @(posedge core_clk);
        bus_rd(CMG_STAT_ADDR);
        chk16("status", 16'h0001, rd_val);
        bus_wr(CMG_STAT_ADDR, 16'h0000);
        bus_rd(CMG_CTRL_ADDR);
        chk16("ctrl_kept", 16'h0200, rd_val);
        bus_rd(4'hF);
        chk16("unmapped", 16'h0000, rd_val);
        $display("test register port done");
        // Mid-run reset while blanking holds the output high
        bus_wr(CMG_CTRL_ADDR, 16'h8200);
        level_req <= 4'h1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk1("blank_pre", 1'b1, blank_active);
        chk1("out_pre", 1'b1, cmp_out);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        chk1("blank_mid_rst", 1'b0, blank_active);
        chk1("out_mid_rst", 1'b0, cmp_out);
        @(posedge core_clk);
        bus_rd(CMG_CTRL_ADDR);
        chk16("ctrl_mid_rst", CMG_CTRL_RST, rd_val);
        $display("test mid-run reset done");
        results();
    end
endmodule : cmg_top_test
